// ===== odc_consts.vh
// Constants for the octal DAC serial command decoder
//==========================================================================
`ifndef ODC_CONSTS_VH
`define ODC_CONSTS_VH

//==========================================================================
// Command word layout
`define ODC_WORD_W      16
`define ODC_CODE_W      10
`define ODC_NCH         8
`define ODC_AC_MSB      15
`define ODC_AC_LSB      12
`define ODC_CODE_MSB    11
`define ODC_CODE_LSB    2

//==========================================================================
// Address/control codes
`define ODC_AC_NOP      4'h0
`define ODC_AC_CH_FIRST 4'h1
`define ODC_AC_CH_LAST  4'h8
`define ODC_AC_SLEEP    4'he
`define ODC_AC_ALL      4'hf

//==========================================================================
// Register map, byte addresses
`define ODC_REG_CTRL    8'h00
`define ODC_REG_STATUS  8'h04
`define ODC_REG_LAST    8'h08
`define ODC_REG_FRAMES  8'h0c
`define ODC_REG_CMD     8'h10
`define ODC_REG_CH_BASE 8'h20
`define ODC_REG_CH_LAST 8'h3c
`define ODC_CTRL_SOFTCLR 0
`define ODC_CTRL_LINKEN  1
`define ODC_CTRL_RST    2'h2
`define ODC_RESP_OKAY   2'h0
`define ODC_RESP_SLVERR 2'h2

`endif

// ===== odc_sync.v
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/10ps
module odc_sync #(
    parameter       W   = 1,
    parameter [W-1:0] RST = {W{1'b0}}
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire         ce,
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    // First stage feeds only the second stage
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            meta_q <= RST;
            sync_q <= RST;
        end
        else if (ce)
        begin
            meta_q <= d;
            sync_q <= meta_q;
        end
    end

    assign q = sync_q;
endmodule

// ===== odc_dac_cmd.v
// Serial command decoder and register slave for an octal 10-bit DAC
`timescale 1ns/10ps
`include "odc_consts.vh"
module odc_dac_cmd #(
    parameter AW = 8
) (
    input  wire                    aclk,
    input  wire                    aresetn,
    input  wire                    ce,
    // AXI4-Lite slave
    input  wire [AW-1:0]           s_axi_awaddr,
    input  wire [2:0]              s_axi_awprot,
    input  wire                    s_axi_awvalid,
    output wire                    s_axi_awready,
    input  wire [31:0]             s_axi_wdata,
    input  wire [3:0]              s_axi_wstrb,
    input  wire                    s_axi_wvalid,
    output wire                    s_axi_wready,
    output wire [1:0]              s_axi_bresp,
    output wire                    s_axi_bvalid,
    input  wire                    s_axi_bready,
    input  wire [AW-1:0]           s_axi_araddr,
    input  wire [2:0]              s_axi_arprot,
    input  wire                    s_axi_arvalid,
    output wire                    s_axi_arready,
    output wire [31:0]             s_axi_rdata,
    output wire [1:0]              s_axi_rresp,
    output wire                    s_axi_rvalid,
    input  wire                    s_axi_rready,
    // Serial link pins
    input  wire                    sclk,
    input  wire                    frame_load_strobe_n,
    input  wire                    sdi,
    output wire                    sdo,
    input  wire                    async_clear_n,
    // Converter side
    output wire [79:0]             chan_codes,
    output wire                    outputs_shutdown
);

    //======================================================================
    // Functions

    // New channel vector after one command word
    function [79:0] f_apply;
        input [79:0] cur;
        input [15:0] w;
        reg   [3:0]  ac;
        reg   [9:0]  code;
        reg   [3:0]  sel;
        integer      i;
        begin
            ac      = w[`ODC_AC_MSB:`ODC_AC_LSB];
            code    = w[`ODC_CODE_MSB:`ODC_CODE_LSB];
            f_apply = cur;
            sel     = 4'h0;
            for (i = 0; i < `ODC_NCH; i = i + 1)
            begin
                sel = sel + 4'h1;
                // Single channel, A first; no-update codes fall through
                if (ac == sel)
                    f_apply[i*10 +: 10] = code;
                if (ac == `ODC_AC_ALL)
                    f_apply[i*10 +: 10] = code;
            end
            // 0000, 1001-1101 and sleep leave cur as it was
        end
    endfunction

    // Sleep only on the sleep code; any other finished word wakes
    function f_sleep;
        input [15:0] w;
        begin
            f_sleep = (w[`ODC_AC_MSB:`ODC_AC_LSB] == `ODC_AC_SLEEP);
        end
    endfunction

    // Word-aligned register hit
    function f_hit;
        input [AW-1:0] a;
        input [7:0]    off;
        begin
            f_hit = (a[7:0] == off);
        end
    endfunction

    //======================================================================
    // Link input synchronisation

    wire [2:0] link_s;
    wire       sclk_s;
    wire       stb_s;
    wire       sdi_s;

    // Strobe idles high so a reset does not look like a frame end
    odc_sync #(
        .W   (3),
        .RST (3'h2)
    ) u_sync (
        .clk   (aclk),
        .rst_n (aresetn),
        .ce    (ce),
        .d     ({sclk, frame_load_strobe_n, sdi}),
        .q     (link_s)
    );

    assign sclk_s = link_s[2];
    assign stb_s  = link_s[1];
    assign sdi_s  = link_s[0];

    //======================================================================
    // Shift register and frame detection

    reg         sclk_prev_q;
    reg         stb_prev_q;
    reg  [15:0] shift_q;
    reg  [15:0] frames_q;
    reg  [1:0]  ctrl_q;
    wire        link_en;
    wire        sclk_rise;
    wire        frame_end;

    assign link_en   = ctrl_q[`ODC_CTRL_LINKEN];
    assign sclk_rise = sclk_s & ~sclk_prev_q;
    // Act on the strobe rising after the last bit
    assign frame_end = stb_s & ~stb_prev_q & link_en;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sclk_prev_q <= 1'b0;
            stb_prev_q  <= 1'b1;
            shift_q     <= 16'h0000;
            frames_q    <= 16'h0000;
        end
        else if (ce)
        begin
            sclk_prev_q <= sclk_s;
            stb_prev_q  <= stb_s;
            // MSB first, one bit per rising clock while framed
            // Still shifting while asleep
            if (sclk_rise && !stb_s && link_en)
                shift_q <= {shift_q[14:0], sdi_s};
            if (frame_end)
                frames_q <= frames_q + 16'h0001;
        end
    end

    // Oldest bit leaves as a new one enters; 16 clocks of delay
    assign sdo = shift_q[15];

    //======================================================================
    // AXI4-Lite write channel

    reg  [AW-1:0] aw_addr_q;
    reg           aw_have_q;
    reg  [31:0]   w_data_q;
    reg  [3:0]    w_strb_q;
    reg           w_have_q;
    reg           bvalid_q;
    reg  [1:0]    bresp_q;
    wire          wr_go;
    wire          wr_map;
    wire          soft_clear;
    wire          cmd_wr;

    assign s_axi_awready = ce & ~aw_have_q & ~bvalid_q;
    assign s_axi_wready  = ce & ~w_have_q & ~bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;

    // Address and data may arrive in either order; act once both are held
    assign wr_go  = aw_have_q & w_have_q;
    assign wr_map = f_hit(aw_addr_q, `ODC_REG_CTRL) |
                    f_hit(aw_addr_q, `ODC_REG_CMD);
    assign soft_clear = wr_go & f_hit(aw_addr_q, `ODC_REG_CTRL) &
                        w_strb_q[0] & w_data_q[`ODC_CTRL_SOFTCLR];
    assign cmd_wr = wr_go & f_hit(aw_addr_q, `ODC_REG_CMD) &
                    (&w_strb_q[1:0]);

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_addr_q <= {AW{1'b0}};
            aw_have_q <= 1'b0;
            w_data_q  <= 32'h00000000;
            w_strb_q  <= 4'h0;
            w_have_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `ODC_RESP_OKAY;
            ctrl_q    <= `ODC_CTRL_RST;
        end
        else if (ce)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_addr_q <= s_axi_awaddr;
                aw_have_q <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
                w_have_q <= 1'b1;
            end
            if (wr_go)
            begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= wr_map ? `ODC_RESP_OKAY : `ODC_RESP_SLVERR;
                if (f_hit(aw_addr_q, `ODC_REG_CTRL) && w_strb_q[0])
                    ctrl_q[`ODC_CTRL_LINKEN] <=
                        w_data_q[`ODC_CTRL_LINKEN];
            end
            else if (bvalid_q && s_axi_bready)
                bvalid_q <= 1'b0;
        end
    end

    //======================================================================
    // Software command slot

    // A register-issued word is decoded like a serial frame. A serial
    // frame ending in the same cycle goes first; the slot waits one turn.
    reg  [15:0] sw_cmd_q;
    reg         sw_pend_q;
    wire        sw_go;

    assign sw_go = sw_pend_q & ~frame_end;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sw_cmd_q  <= 16'h0000;
            sw_pend_q <= 1'b0;
        end
        else if (ce)
        begin
            if (cmd_wr)
            begin
                sw_cmd_q  <= w_data_q[15:0];
                sw_pend_q <= 1'b1;
            end
            else if (sw_go)
                sw_pend_q <= 1'b0;
        end
    end

    //======================================================================
    // Channel registers and sleep state

    reg  [79:0] chan_q;
    reg         sleep_q;
    reg  [15:0] last_q;
    wire        dec_go;
    wire [15:0] dec_word;

    assign dec_go   = frame_end | sw_go;
    assign dec_word = frame_end ? shift_q : sw_cmd_q;

    // The clear pin acts without the clock; release is not synchronised,
    // so the host should not end a frame right at clear release.
    always @(posedge aclk or negedge async_clear_n)
    begin
        if (!async_clear_n)
        begin
            chan_q  <= 80'h0;
            sleep_q <= 1'b0;
        end
        else if (!aresetn)
        begin
            chan_q  <= 80'h0;
            sleep_q <= 1'b0;
        end
        else if (ce)
        begin
            if (soft_clear)
            begin
                chan_q  <= 80'h0;
                sleep_q <= 1'b0;
            end
            else if (dec_go)
            begin
                chan_q  <= f_apply(chan_q, dec_word);
                sleep_q <= f_sleep(dec_word);
            end
        end
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
            last_q <= 16'h0000;
        else if (ce && dec_go)
            last_q <= dec_word;
    end

    // Codes stay stored while buffers are off
    assign chan_codes       = chan_q;
    assign outputs_shutdown = sleep_q;

    //======================================================================
    // AXI4-Lite read channel

    reg  [31:0] rdata_q;
    reg  [1:0]  rresp_q;
    reg         rvalid_q;
    reg  [31:0] rd_d;
    reg  [1:0]  rresp_d;
    reg  [2:0]  rd_ch;

    assign s_axi_arready = ce & ~rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    always @*
    begin
        rd_d    = 32'h00000000;
        rresp_d = `ODC_RESP_OKAY;
        rd_ch   = s_axi_araddr[4:2];
        if (f_hit(s_axi_araddr, `ODC_REG_CTRL))
            rd_d = {30'h0, ctrl_q[`ODC_CTRL_LINKEN], 1'b0};
        else if (f_hit(s_axi_araddr, `ODC_REG_STATUS))
            rd_d = {29'h0, sw_pend_q, link_en, sleep_q};
        else if (f_hit(s_axi_araddr, `ODC_REG_LAST))
            rd_d = {16'h0, last_q};
        else if (f_hit(s_axi_araddr, `ODC_REG_FRAMES))
            rd_d = {16'h0, frames_q};
        else if (f_hit(s_axi_araddr, `ODC_REG_CMD))
            rd_d = {16'h0, sw_cmd_q};
        else if (s_axi_araddr[7:0] >= `ODC_REG_CH_BASE &&
                 s_axi_araddr[7:0] <= `ODC_REG_CH_LAST &&
                 s_axi_araddr[1:0] == 2'h0)
            rd_d = {22'h0, chan_q[rd_ch*10 +: 10]};
        else
            rresp_d = `ODC_RESP_SLVERR;
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rdata_q  <= 32'h00000000;
            rresp_q  <= `ODC_RESP_OKAY;
            rvalid_q <= 1'b0;
        end
        else if (ce)
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                rdata_q  <= rd_d;
                rresp_q  <= rresp_d;
                rvalid_q <= 1'b1;
            end
            else if (rvalid_q && s_axi_rready)
                rvalid_q <= 1'b0;
        end
    end

endmodule

// ===== odc_properties.sv
// Port-level assertions for the DAC command decoder
`timescale 1ns/10ps
module odc_chk (
    input wire        aclk,
    input wire        aresetn,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        frame_load_strobe_n,
    input wire        sdo,
    input wire        async_clear_n,
    input wire [79:0] chan_codes,
    input wire        outputs_shutdown
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    //==========
    // Cycles since strobe rose and since a write; outputs may move only
    // shortly after one of them, since the link pins pass two syncs
    reg  [3:0] ld_q;
    reg  [3:0] wr_q;
    wire       cause = ld_q < 4'h7 || wr_q < 4'h6;
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ld_q <= 4'hf;
            wr_q <= 4'hf;
        end
        else
        begin
            ld_q <= !frame_load_strobe_n ? 4'h0 : ld_q + {3'h0, ld_q != 4'hf};
            wr_q <= s_axi_awvalid && s_axi_awready ? 4'h0
                  : wr_q + {3'h0, wr_q != 4'hf};
        end
    end
    //==========
    // Properties
    sequence s_ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    property p_clear;
        !async_clear_n |-> chan_codes == 80'h0 && !outputs_shutdown;
    endproperty
    property p_codes;
        $changed(chan_codes) && async_clear_n && $past(async_clear_n)
            |-> cause;
    endproperty
    property p_mode;
        $changed(outputs_shutdown) && async_clear_n && $past(async_clear_n)
            |-> cause;
    endproperty
    property p_chain;
        frame_load_strobe_n [*6] |-> $stable(sdo);
    endproperty
    property p_read; s_ar_taken |=> s_axi_rvalid; endproperty
    property p_write; s_wr_taken |-> ##[2:3] s_axi_bvalid; endproperty
    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_clear: assert property (p_clear)
        else $error("channels not cleared");
    a_codes: assert property (p_codes)
        else $error("channel code moved without a command");
    a_mode: assert property (p_mode)
        else $error("shutdown moved without a command");
    a_chain: assert property (p_chain)
        else $error("chain output moved outside a frame");
    a_read: assert property (p_read)
        else $error("read data late");
    a_write: assert property (p_write)
        else $error("write response late");
    a_bhold: assert property (p_bhold)
        else $error("write response dropped");
    a_rhold: assert property (p_rhold)
        else $error("read data dropped");
endmodule
bind odc_dac_cmd odc_chk i_odc_chk (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .frame_load_strobe_n, .sdo, .async_clear_n,
    .chan_codes, .outputs_shutdown
);

// ===== odc_host.sv
// Host model driving the three-wire link and capturing the chain output
`timescale 1ns/10ps
module odc_host (
    output reg  sclk = 1'b0,
    output reg  frame_load_strobe_n = 1'b1,
    output reg  sdi = 1'b0,
    input  wire sdo
);
    reg [15:0] chain_q = 16'h0;
    //==========
    // One frame, MSB first; sclk rests low between frames
    task send(input [31:0] w, input integer n);
        integer k;
        begin
            #37;
            frame_load_strobe_n = 1'b0;
            for (k = n - 1; k >= 0; k = k - 1)
            begin
                sdi = w[k];
                #400;
                chain_q = {chain_q[14:0], sdo};
                sclk = 1'b1;
                #400;
                sclk = 1'b0;
            end
            #400;
            frame_load_strobe_n = 1'b1;
            // Released data line must not keep its last level
            sdi = ~sdi;
            #800;
        end
    endtask
endmodule

// ===== tb_odc_dac_cmd.sv
// Self-checking bench for the octal DAC command decoder
`timescale 1ns/10ps
`include "odc_consts.vh"
module tb_odc_dac_cmd;
    reg         aclk;
    reg         aresetn = 1'b0;
    reg         async_clear_n = 1'b1;
    reg  [7:0]  s_axi_awaddr = 8'h0;
    reg  [31:0] s_axi_wdata = 32'h0;
    reg         s_axi_awvalid = 1'b0;
    reg         s_axi_wvalid = 1'b0;
    reg         s_axi_bready = 1'b0;
    reg  [7:0]  s_axi_araddr = 8'h0;
    reg         s_axi_arvalid = 1'b0;
    reg         s_axi_rready = 1'b0;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire        s_axi_arready, s_axi_rvalid;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire        sclk, frame_load_strobe_n, sdi, sdo, outputs_shutdown;
    wire [79:0] chan_codes;
    integer     mismatches = 0, checked = 0, cyc = 0, c, i;
    integer     frames_m = 0;
    reg  [9:0]  model_m [0:7];
    reg         sleep_m = 1'b0, link_m = 1'b1;
    reg  [15:0] prev_m = 16'h0;
    reg  [31:0] lfsr_q = 32'h5575, rd_q;
    reg  [1:0]  resp_q;

    odc_dac_cmd #(.AW(8)) i_odc_dac_cmd (
        .aclk, .aresetn, .ce(1'b1), .s_axi_awaddr, .s_axi_awprot(3'h0),
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .sclk, .frame_load_strobe_n, .sdi, .sdo,
        .async_clear_n, .chan_codes, .outputs_shutdown
    );
    odc_host i_odc_host (.sclk, .frame_load_strobe_n, .sdi, .sdo);

    initial
    begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    always @(posedge aclk)
    begin
        cyc = cyc + 1;
        if (cyc == 8000)
        begin
            mismatches = mismatches + 1;
            results;
        end
    end
    //==========
    // Model and checking
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task chk(input string nm, input [79:0] seen, input [79:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp)
            begin
                mismatches = mismatches + 1;
                $display("ERROR %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task clr_m;
        begin
            for (i = 0; i < 8; i = i + 1)
                model_m[i] = 10'h0;
            sleep_m = 1'b0;
        end
    endtask
    task apply(input [15:0] w);
        begin
            if (w[15:12] != `ODC_AC_NOP && w[15:12] <= `ODC_AC_CH_LAST)
                model_m[w[15:12] - 4'h1] = w[11:2];
            for (i = 0; i < 8; i = i + 1)
                if (w[15:12] == `ODC_AC_ALL)
                    model_m[i] = w[11:2];
            sleep_m = w[15:12] == `ODC_AC_SLEEP;
        end
    endtask
    task cmp_all;
        reg [79:0] e;
        begin
            for (i = 0; i < 8; i = i + 1)
                e[10 * i +: 10] = model_m[i];
            chk("codes", chan_codes, e);
            chk("shutdown", 80'(outputs_shutdown), 80'(sleep_m));
        end
    endtask
    //==========
    // Bus and link transfers
    task axw(input [7:0] a, input [31:0] d);
        begin
            @(posedge aclk);
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            @(posedge aclk);
            while (!(s_axi_bvalid && s_axi_bready))
            begin
                if (s_axi_awready)
                    s_axi_awvalid <= 1'b0;
                if (s_axi_wready)
                    s_axi_wvalid <= 1'b0;
                // Late ready makes the slave hold its response
                if (s_axi_bvalid)
                    s_axi_bready <= 1'b1;
                @(posedge aclk);
            end
            resp_q = s_axi_bresp;
            s_axi_bready <= 1'b0;
        end
    endtask
    task axr(input [7:0] a);
        begin
            @(posedge aclk);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            @(posedge aclk);
            while (!(s_axi_rvalid && s_axi_rready))
            begin
                if (s_axi_arready)
                    s_axi_arvalid <= 1'b0;
                if (s_axi_rvalid)
                    s_axi_rready <= 1'b1;
                @(posedge aclk);
            end
            rd_q = s_axi_rdata;
            resp_q = s_axi_rresp;
            s_axi_rready <= 1'b0;
        end
    endtask
    task frame(input [31:0] w, input integer n);
        begin
            @(posedge aclk);
            i_odc_host.send(w, n);
            if (link_m && n == 16)
                chk("chain", 80'(i_odc_host.chain_q), 80'(prev_m));
            if (link_m)
            begin
                prev_m = w[15:0];
                apply(w[15:0]);
                frames_m = frames_m + 1;
            end
        end
    endtask
    task results;
        begin
            $display("checked %0d mismatches %0d", checked, mismatches);
            if (mismatches == 0 && checked > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    //==========
    // Main sequence
    initial
    begin
        clr_m;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        cmp_all;
        axr(`ODC_REG_CTRL);
        chk("ctrl", 80'(rd_q), 80'(32'h2));
        for (c = 0; c < 16; c = c + 1)
        begin
            lfsr_q = lfsr(lfsr_q);
            frame({16'h0, c[3:0], lfsr_q[11:0]}, 16);
            cmp_all;
        end
        frame(32'he000, 16);
        frame({20'h0, lfsr_q[23:12]}, 16);
        cmp_all;
        frame(32'he000, 16);
        frame({16'h0, 4'h2, lfsr_q[31:20]}, 16);
        cmp_all;
        lfsr_q = lfsr(lfsr_q);
        frame({12'h0, 4'h5, `ODC_AC_ALL, lfsr_q[11:0]}, 20);
        cmp_all;
        frame(32'he000, 16);
        axr(`ODC_REG_STATUS);
        chk("status", 80'(rd_q), 80'({link_m, sleep_m}));
        @(posedge aclk);
        async_clear_n <= 1'b0;
        #1;
        clr_m;
        cmp_all;
        repeat (3) @(posedge aclk);
        async_clear_n <= 1'b1;
        repeat (3) @(posedge aclk);
        for (c = 0; c < 8; c = c + 1)
        begin
            lfsr_q = lfsr(lfsr_q);
            axw(`ODC_REG_CMD, {16'h0, 4'(c + 1), lfsr_q[11:0]});
            apply({4'(c + 1), lfsr_q[11:0]});
        end
        repeat (3) @(posedge aclk);
        cmp_all;
        for (c = 0; c < 8; c = c + 1)
        begin
            axr(`ODC_REG_CH_BASE + 8'(4 * c));
            chk("chan", 80'(rd_q), 80'(model_m[c]));
        end
        axr(`ODC_REG_CMD);
        chk("cmd", 80'(rd_q), 80'({4'h8, lfsr_q[11:0]}));
        axw(8'h14, 32'h0);
        chk("bresp", 80'(resp_q), 80'(`ODC_RESP_SLVERR));
        axr(8'h14);
        chk("rresp", 80'(resp_q), 80'(`ODC_RESP_SLVERR));
        axw(`ODC_REG_CTRL, 32'h0);
        link_m = 1'b0;
        frame(32'hf3ff, 16);
        cmp_all;
        axw(`ODC_REG_CTRL, 32'h3);
        link_m = 1'b1;
        clr_m;
        repeat (2) @(posedge aclk);
        cmp_all;
        frame({16'h0, 4'h8, lfsr_q[11:0]}, 16);
        cmp_all;
        axr(`ODC_REG_FRAMES);
        chk("frames", 80'(rd_q), 80'(frames_m));
        axr(`ODC_REG_LAST);
        chk("last", 80'(rd_q), 80'(prev_m));
        axr(`ODC_REG_STATUS);
        chk("status", 80'(rd_q), 80'({link_m, sleep_m}));
        results;
    end
endmodule
